// >>> design/pc_fn_gen.sv
`timescale 1ns/100ps
module pc_fn_gen
    import pc_pkg::*;
(
    input wire logic a,
    input wire logic f,
    input wire logic b,
    input wire logic [2:0] mode,
    input wire logic inv_a,
    input wire logic inv_f,
    output logic y
);
    wire logic a_i;
    wire logic f_i;
    wire logic b_i;

    assign a_i = a ^ inv_a; // R1
    assign f_i = f ^ inv_f; // R1
    // In multiplexer mode the second inversion applies to the second data input.
    assign b_i = b ^ inv_f;

    // Codes outside the enumeration fall back to the pass gate.
    assign y = (mode == PC_FN_AND) ? (a_i & f_i) : // R1
               (mode == PC_FN_OR) ? (a_i | f_i) : // R1
               (mode == PC_FN_XOR) ? (a_i ^ f_i) : // R1
               (mode == PC_FN_MUX) ? (f ? b_i : a_i) : // R2
               a_i;
endmodule

// >>> design/pc_pad_cell.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Operation
// (R1) Output function: pass, AND, OR, XOR, inversions.
// (R2) Multiplexer select is the output clock.
// (R3) Critical function input rides the output clock.
// (R4) High tri-state control floats the driver.
// (R5) Output and tri-state polarity invert separately.
// (R6) Open drain: tri-state from data, data zero.
// (R7) Tri-state enable optionally registered.
// (R8) First output activation slew-limited, then configured.
// (R9) Unused pad: pull-up default, other options.
// (R10) Global set/reset forces pad registers.
// (R11) Init choice sets start and reset value.
// (R12) No user set/reset on pad registers.
// (R13) Separate input and output clocks, each invertible.
// (R14) Shared clock enable applied per register; the tri-state register shares the output register's enable choice.
// (R15) Clock enable never inverted in cell.
// (R16) Pad registers default to cleared.
// (R17) Unconnected clock enable reads as one.
// (R18) Output inverted, direct or through flip-flop.
// (R19) Disabled clock enable holds output flip-flop.
module pc_pad_cell
    import pc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic out_data,
    input wire logic out_data_alt,
    input wire logic tri_ctrl,
    input wire logic shared_clock_enable,
    input wire logic output_clock,
    input wire logic input_clock,
    input wire logic global_set_reset,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pullup,
    output logic pad_pulldown,
    output logic pad_slow,
    output logic in_data
);
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W must be at least 4");
    end

    // Active edge of a synchronised clock; inversion picks the falling edge.
    function automatic logic pc_edge(input logic cur, input logic prev, input logic inv);
        return inv ? (prev & ~cur) : (cur & ~prev);
    endfunction

    logic [PC_CTRL_W-1:0] ctrl_r;
    logic glb_sw_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic oc_prev_r;
    logic ic_prev_r;
    logic out_q_r;
    logic ts_q_r;
    logic in_q_r;
    logic start_r;
    logic pad_out_r;
    logic pad_oe_n_r;
    logic pad_pullup_r;
    logic pad_pulldown_r;
    logic pad_slow_r;
    logic in_data_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Pad-side inputs arrive from outside this clock and pass two flip-flops.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            oc_prev_r <= 1'b0;
            ic_prev_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= {pad_in, global_set_reset, input_clock, output_clock};
            sync2_r <= sync1_r;
            oc_prev_r <= sync2_r[0];
            ic_prev_r <= sync2_r[1];
        end
    end

    wire logic oc_lvl;
    wire logic ic_lvl;
    wire logic glb_pin;
    wire logic pad_s;
    assign oc_lvl = sync2_r[0];
    assign ic_lvl = sync2_r[1];
    assign glb_pin = sync2_r[2];
    assign pad_s = sync2_r[3];

    wire logic [2:0] fn_mode;
    wire logic fn_none;
    wire logic inv_a;
    wire logic inv_f;
    wire logic out_inv;
    wire logic ts_inv;
    wire logic out_ff_en;
    wire logic ts_ff_en;
    wire logic in_ff_en;
    wire logic in_clk_inv;
    wire logic out_clk_inv;
    wire logic ce_in_apply;
    wire logic ce_out_apply;
    wire logic ce_conn;
    wire logic in_init;
    wire logic out_init;
    wire logic ts_init;
    wire logic open_drain;
    wire logic slew_fast;
    wire logic pad_used;
    wire logic [1:0] un_mode;
    assign fn_mode = ctrl_r[PC_B_FN +: PC_FN_W];
    assign fn_none = (fn_mode == PC_FN_NONE);
    assign inv_a = ctrl_r[PC_B_INV_A];
    assign inv_f = ctrl_r[PC_B_INV_F];
    assign out_inv = ctrl_r[PC_B_OUT_INV];
    assign ts_inv = ctrl_r[PC_B_TS_INV];
    assign out_ff_en = ctrl_r[PC_B_OUT_FF];
    assign ts_ff_en = ctrl_r[PC_B_TS_FF];
    assign in_ff_en = ctrl_r[PC_B_IN_FF];
    assign in_clk_inv = ctrl_r[PC_B_IN_CLK_INV];
    assign out_clk_inv = ctrl_r[PC_B_OUT_CLK_INV];
    assign ce_in_apply = ctrl_r[PC_B_CE_IN];
    assign ce_out_apply = ctrl_r[PC_B_CE_OUT];
    assign ce_conn = ctrl_r[PC_B_CE_CONN];
    assign in_init = ctrl_r[PC_B_IN_INIT];
    assign out_init = ctrl_r[PC_B_OUT_INIT];
    assign ts_init = ctrl_r[PC_B_TS_INIT];
    assign open_drain = ctrl_r[PC_B_OPEN_DRAIN];
    assign slew_fast = ctrl_r[PC_B_SLEW_FAST];
    assign pad_used = ctrl_r[PC_B_PAD_USED];
    assign un_mode = ctrl_r[PC_B_UNUSED +: PC_UNUSED_W];

    // Besides rst_n, the global set/reset pin and the GLB command bit are the only things that can force the pad registers.
    wire logic glb_ev;
    assign glb_ev = glb_pin | glb_sw_r; // R10 R12

    wire logic ce_eff;
    wire logic out_ce;
    wire logic in_ce;
    wire logic oc_edge;
    wire logic ic_edge;
    assign ce_eff = shared_clock_enable | ~ce_conn; // R15 R17
    assign out_ce = ~ce_out_apply | ce_eff; // R14
    assign in_ce = ~ce_in_apply | ce_eff; // R14
    assign oc_edge = pc_edge(oc_lvl, oc_prev_r, out_clk_inv); // R13
    assign ic_edge = pc_edge(ic_lvl, ic_prev_r, in_clk_inv); // R13

    wire logic o_inv;
    wire logic ts_raw;
    wire logic out_q_nxt;
    wire logic ts_q_nxt;
    wire logic in_q_nxt;
    assign o_inv = out_data ^ out_inv; // R5 R18
    assign ts_raw = tri_ctrl ^ ts_inv; // R5
    assign out_q_nxt = glb_ev ? out_init : ((oc_edge & out_ce) ? o_inv : out_q_r); // R11 R19
    assign ts_q_nxt = glb_ev ? ts_init : ((oc_edge & out_ce) ? ts_raw : ts_q_r); // R7 R11
    assign in_q_nxt = glb_ev ? in_init : ((ic_edge & in_ce) ? pad_s : in_q_r); // R10 R11

    // Power-up leaves every pad register cleared, matching the reset config.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_q_r <= PC_CLEARED; // R16
            ts_q_r <= PC_CLEARED; // R16
            in_q_r <= PC_CLEARED; // R16
        end else if (clk_en) begin
            out_q_r <= out_q_nxt;
            ts_q_r <= ts_q_nxt;
            in_q_r <= in_q_nxt;
        end
    end

    // The critical input of the function generator is the output clock line.
    wire logic fn_y;
    pc_fn_gen u_fn (
        .a(out_data),
        .f(oc_lvl), // R3
        .b(out_data_alt),
        .mode(fn_mode),
        .inv_a(inv_a),
        .inv_f(inv_f),
        .y(fn_y)
    );

    // With the function generator active the output clock is consumed as data,
    // so the output flip-flop is bypassed.
    wire logic o_final;
    wire logic t_base;
    wire logic t_eff;
    wire logic d_drv;
    wire logic drive_nxt;
    wire logic pad_out_nxt;
    assign o_final = fn_none ? (out_ff_en ? out_q_r : o_inv) : (fn_y ^ out_inv); // R1 R18
    assign t_base = ts_ff_en ? ts_q_r : ts_raw; // R7
    assign t_eff = open_drain ? o_final : t_base; // R6
    assign d_drv = open_drain ? 1'b0 : o_final; // R6
    assign drive_nxt = pad_used ? ~t_eff : (un_mode == PC_UN_DRIVEN); // R4 R9
    assign pad_out_nxt = pad_used ? d_drv : 1'b0; // R9

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pad_out_r <= 1'b0;
            pad_oe_n_r <= 1'b1;
            pad_pullup_r <= 1'b1;
            pad_pulldown_r <= 1'b0;
            pad_slow_r <= 1'b1;
            in_data_r <= 1'b0;
            start_r <= 1'b1;
        end else if (clk_en) begin
            pad_out_r <= pad_out_nxt;
            pad_oe_n_r <= ~drive_nxt; // R4
            pad_pullup_r <= ~pad_used & (un_mode == PC_UN_PULLUP); // R9
            pad_pulldown_r <= ~pad_used & (un_mode == PC_UN_PULLDOWN); // R9
            pad_slow_r <= start_r | ~slew_fast; // R8
            in_data_r <= in_ff_en ? in_q_r : pad_s;
            start_r <= start_r & pad_oe_n_r; // R8
        end
    end

    // APB slave: one wait state, so every access completes on its second cycle.
    wire logic sel_ctrl;
    wire logic sel_glb;
    wire logic sel_stat;
    wire logic hit;
    wire logic acc;
    wire logic wr;
    wire logic [PC_STAT_W-1:0] status;
    wire logic [31:0] rdata;
    assign sel_ctrl = (paddr == ADDR_W'(PC_OFF_CTRL));
    assign sel_glb = (paddr == ADDR_W'(PC_OFF_GLB));
    assign sel_stat = (paddr == ADDR_W'(PC_OFF_STAT));
    assign hit = sel_ctrl | sel_glb | sel_stat;
    assign acc = psel & penable;
    assign wr = acc & pready_r & pwrite & hit;
    assign status = {~pad_oe_n_r, start_r, ts_q_r, out_q_r, in_q_r, pad_s};
    assign rdata = sel_ctrl ? {{(32-PC_CTRL_W){1'b0}}, ctrl_r} :
                   sel_stat ? {{(32-PC_STAT_W){1'b0}}, status} : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r <= PC_CTRL_RST; // R16
            glb_sw_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            if (wr && sel_ctrl) begin
                ctrl_r <= pwdata[PC_CTRL_W-1:0];
            end
            glb_sw_r <= wr & sel_glb & pwdata[PC_B_GLB]; // R10
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~hit;
            if (acc && !pready_r) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pad_out = pad_out_r;
    assign pad_oe_n = pad_oe_n_r;
    assign pad_pullup = pad_pullup_r;
    assign pad_pulldown = pad_pulldown_r;
    assign pad_slow = pad_slow_r;
    assign in_data = in_data_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_access;
        psel && penable && clk_en;
    endsequence
    sequence s_first_drive;
        clk_en && start_r && drive_nxt;
    endsequence

    a_apb_wait_state:
    assert property (s_setup ##1 s_access |=> pready_r)
        else $error("pready did not rise on the second access cycle");

    a_glb_out_init: // R10
    assert property (clk_en && glb_ev |=> out_q_r == $past(out_init))
        else $error("output register missed its init value on set/reset");

    a_glb_in_init: // R11
    assert property (clk_en && glb_ev |=> in_q_r == $past(in_init) && ts_q_r == $past(ts_init))
        else $error("input or tri-state register missed its init value");

    a_ce_out_hold: // R19
    assert property (clk_en && oc_edge && ce_conn && ce_out_apply && !shared_clock_enable
                     && !glb_ev |=> $stable(out_q_r))
        else $error("output register changed with clock enable low");

    a_out_capture: // R13
    assert property (clk_en && oc_edge && out_ce && !glb_ev |=> out_q_r == $past(o_inv))
        else $error("output register did not capture on its active edge");

    a_open_drain_low: // R6
    assert property (clk_en && pad_used && open_drain |=> !pad_out_r)
        else $error("open-drain pad drove a high level");

    a_tristate_float: // R4
    assert property (clk_en && pad_used && t_eff |=> pad_oe_n_r)
        else $error("driver enabled while tri-state control asserted");

    a_unused_pullup: // R9
    assert property (clk_en && !pad_used && un_mode == PC_UN_PULLUP
                     |=> pad_pullup_r && pad_oe_n_r && !pad_pulldown_r)
        else $error("unused pad not held by the pull-up");

    a_soft_start: // R8
    assert property (s_first_drive |=> pad_slow_r && !pad_oe_n_r ##1 (!clk_en || !start_r))
        else $error("first output activation was not slew limited");

    a_mux_select: // R2
    assert property (clk_en && pad_used && !open_drain && fn_mode == PC_FN_MUX && !inv_a
                     && !inv_f && !out_inv && !t_eff
                     |=> pad_out_r == ($past(oc_lvl) ? $past(out_data_alt) : $past(out_data)))
        else $error("multiplexer select did not follow the output clock");
endmodule

// >>> dv/pc_pad_partner.sv
`timescale 1ns/100ps
module pc_pad_partner (
    input wire logic clock,
    input wire logic pad_out,
    input wire logic pad_oe_n,
    input wire logic pad_pullup,
    input wire logic pad_pulldown,
    input wire logic drv_en,
    input wire logic drv_val,
    output logic pad_level
);
    logic flip_r = 1'b0;
    always @(posedge clock) flip_r <= ~flip_r;
    // A floating pad shows a changing level so that a stale value never passes for a drive.
    always_comb begin
        if (!pad_oe_n && drv_en) pad_level = 1'bx;
        else if (!pad_oe_n) pad_level = pad_out;
        else if (drv_en) pad_level = drv_val;
        else if (pad_pullup) pad_level = 1'b1;
        else if (pad_pulldown) pad_level = 1'b0;
        else pad_level = flip_r;
    end
endmodule

// >>> dv/tb_pad_cell_output_and_clocking.sv
`timescale 1ns/100ps
module tb_pad_cell_output_and_clocking
    import pc_pkg::*;
;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r, v;
    logic [31:0] seed = 32'h0000eaea;
    logic pready, pslverr, err, lvl, pad_in, in_data;
    logic od = 1'b0, oda = 1'b0, tc = 1'b0, sce = 1'b1, ock = 1'b0, ick = 1'b0, glb = 1'b0;
    logic pad_out, pad_oe_n, pad_pullup, pad_pulldown, pad_slow;
    logic drv_en = 1'b0, drv_val = 1'b0, ce = 1'b1;
    int bad_count = 0, total_checks = 0, cyc = 0;
    pc_pad_cell DUT (.clock(clock), .rst_n(rst_n), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_data(od),
        .out_data_alt(oda), .tri_ctrl(tc), .shared_clock_enable(sce),
        .output_clock(ock), .input_clock(ick), .global_set_reset(glb), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
        .pad_pulldown(pad_pulldown), .pad_slow(pad_slow), .in_data(in_data));
    pc_pad_partner far_end (.clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .drv_en(drv_en),
        .drv_val(drv_val), .pad_level(pad_in));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Output level before the output inversion: a = data, f = output clock level.
    function automatic logic fexp(logic [31:0] q);
        logic a, f;
        a = q[9] ^ q[3];
        f = q[11] ^ q[4];
        case (q[2:0])
            3'h2: return a & f;
            3'h3: return a | f;
            3'h4: return a ^ f;
            3'h5: return q[11] ? q[10] ^ q[4] : a;
            default: return a;
        endcase
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // The request is held until pready is seen high at an edge, or for at most 20 edges.
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic w(int k);
        repeat (k) @(posedge clock);
    endtask
    // Toggles the input (s=1) or output clock k times, letting the synchroniser settle.
    task automatic tog(bit s, int k);
        repeat (k) begin
            @(posedge clock);
            if (s) ick <= ~ick;
            else ock <= ~ock;
            w(6);
        end
    endtask
    initial begin
        w(3);
        rst_n <= 1'b1;
        w(1);
        chk("oe_n", 1, pad_oe_n);
        chk("pullup", 1, pad_pullup);
        chk("pulldown", 0, pad_pulldown);
        chk("slow", 1, pad_slow);
        apb(1'b0, PC_OFF_CTRL, 32'h0);
        chk("ctrl", 0, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("slverr", 1, err);
        apb(1'b1, PC_OFF_CTRL, 32'h00180000);
        for (int n = 0; n < 20 && pad_oe_n !== 1'b0; n++) @(posedge clock);
        chk("first_slow", 1, pad_slow);
        w(2);
        chk("later_slow", 0, pad_slow);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, PC_OFF_CTRL, m << 21);
            w(3);
            chk("unused_pu", m == 0, pad_pullup);
            chk("unused_pd", m == 1, pad_pulldown);
            chk("unused_oe", m != 2, pad_oe_n);
        end
        // Random output functions, polarities and open drain.
        repeat (60) begin
            r = xs();
            if (r[2:0] > 3'h5) r[2:0] = 3'h1;
            if (r[2:0] == 3'h0) r[3] = 1'b0;
            od <= r[9];
            oda <= r[10];
            ock <= r[11];
            tc <= r[12];
            apb(1'b1, PC_OFF_CTRL, (r & 32'h0004007f) | 32'h00100000);
            w(6);
            lvl = fexp(r) ^ r[5];
            chk("oe_n", r[18] ? lvl : r[12] ^ r[6], pad_oe_n);
            chk("out", r[18] ? 1'b0 : lvl, pad_out);
        end
        v = 32'h00100080;
        tc <= 1'b0;
        od <= 1'b1;
        ock <= 1'b0;
        apb(1'b1, PC_OFF_CTRL, v);
        w(6);
        tog(0, 1);
        chk("ff_rise", 1, pad_out);
        od <= 1'b0;
        tog(0, 1);
        chk("ff_fall", 1, pad_out);
        apb(1'b1, PC_OFF_CTRL, v | 32'h800);
        tog(0, 1);
        chk("inv_rise", 1, pad_out);
        tog(0, 1);
        chk("inv_fall", 0, pad_out);
        apb(1'b1, PC_OFF_CTRL, v | 32'h6000);
        sce <= 1'b0;
        od <= 1'b1;
        tog(0, 2);
        chk("ce_hold", 0, pad_out);
        sce <= 1'b1;
        tog(0, 2);
        chk("ce_on", 1, pad_out);
        apb(1'b1, PC_OFF_CTRL, v | 32'h2000);
        sce <= 1'b0;
        od <= 1'b0;
        tog(0, 2);
        chk("ce_open", 0, pad_out);
        apb(1'b1, PC_OFF_CTRL, v | 32'h10000);
        apb(1'b1, PC_OFF_GLB, 32'h1);
        w(3);
        chk("glb_set", 1, pad_out);
        apb(1'b1, PC_OFF_CTRL, v);
        glb <= 1'b1;
        w(6);
        glb <= 1'b0;
        w(3);
        chk("glb_clr", 0, pad_out);
        apb(1'b1, PC_OFF_CTRL, 32'h00100100);
        tc <= 1'b1;
        tog(0, 2);
        chk("ts_ff", 1, pad_oe_n);
        tc <= 1'b0;
        w(6);
        chk("ts_hold", 1, pad_oe_n);
        tog(0, 2);
        chk("ts_on", 0, pad_oe_n);
        v = 32'h00600200;
        drv_en <= 1'b1;
        drv_val <= 1'b1;
        apb(1'b1, PC_OFF_CTRL, v);
        tog(1, 2);
        chk("in_ff", 1, in_data);
        drv_val <= 1'b0;
        apb(1'b1, PC_OFF_CTRL, v | 32'h5000);
        sce <= 1'b0;
        tog(1, 2);
        chk("in_ce", 1, in_data);
        apb(1'b1, PC_OFF_CTRL, v);
        apb(1'b1, PC_OFF_GLB, 32'h1);
        w(3);
        chk("in_glb", 0, in_data);
        apb(1'b1, PC_OFF_CTRL, v | 32'h8000);
        apb(1'b1, PC_OFF_GLB, 32'h1);
        w(3);
        chk("in_init", 1, in_data);
        apb(1'b1, PC_OFF_CTRL, 32'h00600000);
        w(6);
        chk("in_direct", 0, in_data);
        // With the block clock enable low nothing may move, not even the synchronisers.
        ce <= 1'b0;
        drv_val <= 1'b1;
        w(6);
        chk("freeze", 0, in_data);
        ce <= 1'b1;
        w(6);
        chk("thaw", 1, in_data);
        apb(1'b0, PC_OFF_CTRL, 32'h0);
        chk("ctrl_rd", 32'h00600000, rd);
        apb(1'b0, PC_OFF_STAT, 32'h0);
        chk("stat", (1 << PC_S_PAD_IN) | (1 << PC_S_IN_Q), rd);
        give_verdict();
    end
endmodule

// >>> include/pc_pkg.sv
package pc_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] PC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PC_OFF_GLB = 8'h04;
    localparam logic [7:0] PC_OFF_STAT = 8'h08;

    // Configuration register layout and reset value.
    localparam int PC_CTRL_W = 23;
    localparam logic [PC_CTRL_W-1:0] PC_CTRL_RST = 23'h000000;
    localparam int PC_B_FN = 0;
    localparam int PC_FN_W = 3;
    localparam int PC_B_INV_A = 3;
    localparam int PC_B_INV_F = 4;
    localparam int PC_B_OUT_INV = 5;
    localparam int PC_B_TS_INV = 6;
    localparam int PC_B_OUT_FF = 7;
    localparam int PC_B_TS_FF = 8;
    localparam int PC_B_IN_FF = 9;
    localparam int PC_B_IN_CLK_INV = 10;
    localparam int PC_B_OUT_CLK_INV = 11;
    localparam int PC_B_CE_IN = 12;
    localparam int PC_B_CE_OUT = 13;
    localparam int PC_B_CE_CONN = 14;
    localparam int PC_B_IN_INIT = 15;
    localparam int PC_B_OUT_INIT = 16;
    localparam int PC_B_TS_INIT = 17;
    localparam int PC_B_OPEN_DRAIN = 18;
    localparam int PC_B_SLEW_FAST = 19;
    localparam int PC_B_PAD_USED = 20;
    localparam int PC_B_UNUSED = 21;
    localparam int PC_UNUSED_W = 2;

    // Global set/reset command bit.
    localparam int PC_B_GLB = 0;

    // Status register layout.
    localparam int PC_STAT_W = 6;
    localparam int PC_S_PAD_IN = 0;
    localparam int PC_S_IN_Q = 1;
    localparam int PC_S_OUT_Q = 2;
    localparam int PC_S_TS_Q = 3;
    localparam int PC_S_START = 4;
    localparam int PC_S_DRIVE = 5;

    // Register value of the cleared state.
    localparam logic PC_CLEARED = 1'b0;

    typedef enum logic [2:0] {
        PC_FN_NONE = 3'b000,
        PC_FN_PASS = 3'b001,
        PC_FN_AND = 3'b010,
        PC_FN_OR = 3'b011,
        PC_FN_XOR = 3'b100,
        PC_FN_MUX = 3'b101
    } pc_fn_t;

    typedef enum logic [1:0] {
        PC_UN_PULLUP = 2'b00,
        PC_UN_PULLDOWN = 2'b01,
        PC_UN_DRIVEN = 2'b10,
        PC_UN_EXTERNAL = 2'b11
    } pc_unused_t;

endpackage
